// *** rtl/coir_cfg.svh ***
// Constants of the core interrupt and timer option register block.
// Assumes inclusion by bare name from the package only.
`ifndef COIR_CFG_SVH
`define COIR_CFG_SVH

// Register offsets on the plain register port
`define COIR_ADDR_W          8
`define COIR_OFS_INT_CTRL    8'h0b
`define COIR_OFS_TMR_OPT     8'h81
`define COIR_OFS_EVT_STATUS  8'h90
`define COIR_OFS_EVT_MASK    8'h91

// Reset values
`define COIR_RST_TMR_OPT     8'hff
`define COIR_RST_INT_CTRL    8'h00
`define COIR_RST_EVT_STATUS  4'h0
`define COIR_RST_EVT_MASK    4'h0

// Timer option field positions
`define COIR_OPT_PULLUP_DIS  7
`define COIR_OPT_EXT_EDGE    6
`define COIR_OPT_CLK_SRC     5
`define COIR_OPT_SRC_EDGE    4
`define COIR_OPT_PSC_ASSIGN  3
`define COIR_OPT_RATE_HI     2
`define COIR_OPT_RATE_LO     0

// Interrupt control field positions
`define COIR_IC_GIE          7
`define COIR_IC_PERIPHERAL_INT_ENABLE         6
`define COIR_IC_TOV_EN       5
`define COIR_IC_EXT_EN       4
`define COIR_IC_CHG_EN       3
`define COIR_IC_TOV_FLAG     2
`define COIR_IC_EXT_FLAG     1
`define COIR_IC_CHG_FLAG     0

// Event status and mask bits
`define COIR_EVT_W           4
`define COIR_EVT_TOV         0
`define COIR_EVT_EXT         1
`define COIR_EVT_CHG         2
`define COIR_EVT_WDT         3

`endif

// *** rtl/coir_pkg.sv ***
// Types shared by the core interrupt and timer option register block.
// Assumes coir_cfg.svh sits on the include path.
`include "coir_cfg.svh"

package coir_pkg;

  typedef logic [7:0] coir_byte_type;

  typedef logic [`COIR_EVT_W-1:0] coir_evt_type;

  // Shared prescaler counter state
  typedef struct packed {
    logic [7:0] cnt;
  } coir_psc_state_type;

endpackage

// *** rtl/coir_prescaler.sv ***
// Shared prescaler serving either the timer or the watchdog.
// Assumes tick_in is a one-cycle pulse on clk_in.
`timescale 1ns/10ps
`default_nettype none

module coir_prescaler
  import coir_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] rate_in,
  input  wire logic       to_timer_in,
  input  wire logic       clear_in,
  output logic            tick_out
);

  coir_psc_state_type state_q;
  coir_psc_state_type state_d;
  logic [CNT_W-1:0]   mask;

  // Low-bit mask giving division by 2^(n+1) or 2^n
  function automatic logic [CNT_W-1:0] rate_mask(
    input logic [2:0] rate,
    input logic       timer
  );
    logic [3:0] k;
    k = timer ? ({1'b0, rate} + 4'h1) : {1'b0, rate};
    rate_mask = CNT_W'((9'h001 << k) - 9'h001);
  endfunction

  assign mask     = rate_mask(rate_in, to_timer_in);
  assign tick_out = tick_in & ((state_q.cnt & mask) == mask);

  always_comb begin
    state_d = state_q;
    if (clear_in) begin
      state_d.cnt = '0;
    end else if (tick_in) begin
      state_d.cnt = state_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

`default_nettype wire

// *** rtl/coir_regs.sv ***
// Timer option and interrupt control registers with event logic.
// Assumes a same-clock register master and pins from outside the clock.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module coir_regs
  import coir_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Pins from outside the clock domain
  input  wire logic       timer_ext_clock_pin_in,
  input  wire logic       ext_int_pin_in,
  input  wire logic [3:0] port_b_a_upper_in,
  // Same-clock core signals
  input  wire logic       instruction_cycle_clock_in,
  input  wire logic       port_b_read_in,
  input  wire logic       timer_overflow_in,
  input  wire logic       watchdog_base_tick_in,
  input  wire logic       peripheral_int_pending_in,
  // Outputs
  output logic            timer_increment_out,
  output logic            watchdog_tick_out,
  output logic            port_b_pullup_disable_out,
  output logic            cpu_int_req_out,
  output logic            irq_out
);

  typedef struct packed {
    coir_byte_type opt;
    coir_byte_type ictl;
    coir_evt_type  evt_status;
    coir_evt_type  evt_mask;
    coir_byte_type rdata;
    logic [1:0]    tck_sync;
    logic          tck_prev;
    logic [1:0]    ext_sync;
    logic          ext_prev;
    logic [3:0]    pb_meta;
    logic [3:0]    pb_sync;
    logic [3:0]    pb_latch;
    logic          tmr_inc;
    logic          wdt_tick;
  } coir_regs_state_type;

  coir_regs_state_type state_q;
  coir_regs_state_type state_d;

  logic       wr_opt;
  logic       wr_ictl;
  logic       wr_status;
  logic       wr_mask;
  logic       psc_to_timer;
  logic [2:0] rate;
  logic       tck_now;
  logic       tck_rise;
  logic       tck_fall;
  logic       ext_now;
  logic       ext_rise;
  logic       ext_fall;
  logic       src_tick;
  logic       psc_in;
  logic       psc_out;
  logic       psc_clear;
  logic       ev_tov;
  logic       ev_ext;
  logic       ev_chg;
  logic       ev_wdt;
  coir_evt_type events;
  logic       any_enabled;

  // Register decode
  assign wr_opt    = reg_wr_in && (reg_addr_in == `COIR_OFS_TMR_OPT);
  assign wr_ictl   = reg_wr_in && (reg_addr_in == `COIR_OFS_INT_CTRL);
  assign wr_status = reg_wr_in && (reg_addr_in == `COIR_OFS_EVT_STATUS);
  assign wr_mask   = reg_wr_in && (reg_addr_in == `COIR_OFS_EVT_MASK);

  // Option fields
  assign psc_to_timer = ~state_q.opt[`COIR_OPT_PSC_ASSIGN];
  assign rate = state_q.opt[`COIR_OPT_RATE_HI:`COIR_OPT_RATE_LO];

  // Edges on synchronised pins; first sync stage is never read here
  assign tck_now  = state_q.tck_sync[1];
  assign tck_rise = tck_now & ~state_q.tck_prev;
  assign tck_fall = ~tck_now & state_q.tck_prev;
  assign ext_now  = state_q.ext_sync[1];
  assign ext_rise = ext_now & ~state_q.ext_prev;
  assign ext_fall = ~ext_now & state_q.ext_prev;

  // Timer source tick
  always_comb begin
    if (state_q.opt[`COIR_OPT_CLK_SRC]) begin
      if (state_q.opt[`COIR_OPT_SRC_EDGE]) begin
        src_tick = tck_fall;
      end else begin
        src_tick = tck_rise;
      end
    end else begin
      src_tick = instruction_cycle_clock_in;
    end
  end

  // Prescaler feeds one consumer; the other sees ticks directly
  assign psc_in    = psc_to_timer ? src_tick : watchdog_base_tick_in;
  assign psc_clear = wr_opt &&
    (reg_wdata_in[`COIR_OPT_PSC_ASSIGN] !=
     state_q.opt[`COIR_OPT_PSC_ASSIGN]);

  coir_prescaler #(
    .CNT_W(8)
  ) u_prescaler (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (psc_in),
    .rate_in    (rate),
    .to_timer_in(psc_to_timer),
    .clear_in   (psc_clear),
    .tick_out   (psc_out)
  );

  // Interrupt events
  assign ev_tov = timer_overflow_in;
  assign ev_ext = state_q.opt[`COIR_OPT_EXT_EDGE] ? ext_rise : ext_fall;
  assign ev_chg = (state_q.pb_sync != state_q.pb_latch);
  assign ev_wdt = state_q.wdt_tick;

  always_comb begin
    events               = '0;
    events[`COIR_EVT_TOV] = ev_tov;
    events[`COIR_EVT_EXT] = ev_ext;
    events[`COIR_EVT_CHG] = ev_chg;
    events[`COIR_EVT_WDT] = ev_wdt;
  end

  // Next state
  always_comb begin
    state_d = state_q;

    // Pin synchronisers
    state_d.tck_sync = {state_q.tck_sync[0], timer_ext_clock_pin_in};
    state_d.tck_prev = state_q.tck_sync[1];
    state_d.ext_sync = {state_q.ext_sync[0], ext_int_pin_in};
    state_d.ext_prev = state_q.ext_sync[1];
    state_d.pb_meta  = port_b_a_upper_in;
    state_d.pb_sync  = state_q.pb_meta;

    // A port read takes a fresh snapshot, ending the mismatch
    if (port_b_read_in) begin
      state_d.pb_latch = state_q.pb_sync;
    end

    // Prescaler routing to the two consumers
    if (psc_to_timer) begin
      state_d.tmr_inc  = psc_out;
      state_d.wdt_tick = watchdog_base_tick_in;
    end else begin
      state_d.tmr_inc  = src_tick;
      state_d.wdt_tick = psc_out;
    end

    // Timer option register, all bits writable
    if (wr_opt) begin
      state_d.opt = reg_wdata_in;
    end

    // Interrupt control: write first, then hardware sets win
    if (wr_ictl) begin
      state_d.ictl = reg_wdata_in;
    end
    if (ev_tov) begin
      state_d.ictl[`COIR_IC_TOV_FLAG] = 1'b1;
    end
    if (ev_ext) begin
      state_d.ictl[`COIR_IC_EXT_FLAG] = 1'b1;
    end
    if (ev_chg) begin
      state_d.ictl[`COIR_IC_CHG_FLAG] = 1'b1;
    end

    // Event status: write one to clear, a new event wins
    if (wr_status) begin
      state_d.evt_status = state_q.evt_status &
        ~reg_wdata_in[`COIR_EVT_W-1:0];
    end
    state_d.evt_status = state_d.evt_status | events;

    if (wr_mask) begin
      state_d.evt_mask = reg_wdata_in[`COIR_EVT_W-1:0];
    end

    // Read data stand one cycle after the strobe
    state_d.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `COIR_OFS_TMR_OPT: begin
          state_d.rdata = state_q.opt;
        end
        `COIR_OFS_INT_CTRL: begin
          state_d.rdata = state_q.ictl;
        end
        `COIR_OFS_EVT_STATUS: begin
          state_d.rdata = {4'h0, state_q.evt_status};
        end
        `COIR_OFS_EVT_MASK: begin
          state_d.rdata = {4'h0, state_q.evt_mask};
        end
        default: begin
          state_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q            <= '0;
      state_q.opt        <= `COIR_RST_TMR_OPT;
      state_q.ictl       <= `COIR_RST_INT_CTRL;
      state_q.evt_status <= `COIR_RST_EVT_STATUS;
      state_q.evt_mask   <= `COIR_RST_EVT_MASK;
    end else begin
      state_q <= state_d;
    end
  end

  // Processor request
  assign any_enabled =
    (state_q.ictl[`COIR_IC_TOV_EN] & state_q.ictl[`COIR_IC_TOV_FLAG]) |
    (state_q.ictl[`COIR_IC_EXT_EN] & state_q.ictl[`COIR_IC_EXT_FLAG]) |
    (state_q.ictl[`COIR_IC_CHG_EN] & state_q.ictl[`COIR_IC_CHG_FLAG]) |
    (state_q.ictl[`COIR_IC_PERIPHERAL_INT_ENABLE] & peripheral_int_pending_in);

  assign cpu_int_req_out = state_q.ictl[`COIR_IC_GIE] & any_enabled;

  // Outputs
  assign reg_rdata_out             = state_q.rdata;
  assign timer_increment_out       = state_q.tmr_inc;
  assign watchdog_tick_out         = state_q.wdt_tick;
  assign port_b_pullup_disable_out = state_q.opt[`COIR_OPT_PULLUP_DIS];
  assign irq_out = |(state_q.evt_status & state_q.evt_mask);

endmodule

`default_nettype wire

// *** verification/coir_regs_sva.sv ***
// Checker for the core interrupt and timer option register block.
// Assumes it is bound to coir_regs and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module coir_regs_sva (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       instruction_cycle_clock_in,
  input wire logic       watchdog_base_tick_in,
  input wire logic       peripheral_int_pending_in,
  input wire logic       timer_increment_out,
  input wire logic       watchdog_tick_out,
  input wire logic       port_b_pullup_disable_out,
  input wire logic       cpu_int_req_out,
  input wire logic       irq_out
);
  logic [7:0] opt_q;
  logic [7:3] ic_q;
  logic [3:0] mask_q;

  // Shadows of the software-only register bits
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      opt_q  <= 8'hff;
      ic_q   <= '0;
      mask_q <= '0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h81) opt_q <= reg_wdata_in;
      if (reg_addr_in == 8'h0b) ic_q <= reg_wdata_in[7:3];
      if (reg_addr_in == 8'h91) mask_q <= reg_wdata_in[3:0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_rdata_idle:
    assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  chk_opt_rw:
    assert property (reg_wr_in && reg_addr_in == 8'h81 ##1
      reg_rd_in && reg_addr_in == 8'h81
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("option readback differs");
  chk_pullup_bit:
    assert property ($past(reg_wr_in && reg_addr_in == 8'h81)
      |-> port_b_pullup_disable_out == $past(reg_wdata_in[7]))
    else $error("pull-up output wrong");
  chk_gie_gate:
    assert property (!ic_q[7] |-> !cpu_int_req_out)
    else $error("request without global enable");
  chk_req_peri:
    assert property (ic_q[7] && ic_q[6] && peripheral_int_pending_in
      |-> cpu_int_req_out)
    else $error("peripheral request missing");
  chk_irq_mask:
    assert property (mask_q == 4'h0 |-> !irq_out)
    else $error("irq with empty mask");
  chk_tmr_direct:
    assert property (opt_q[5:3] == 3'h1 && instruction_cycle_clock_in
      |=> timer_increment_out)
    else $error("timer tick lost");
  chk_tmr_div2:
    assert property (opt_q[5:0] == 6'h00 && timer_increment_out
      |=> !timer_increment_out)
    else $error("timer not divided");
  chk_wdt_direct:
    assert property (!opt_q[3] && watchdog_base_tick_in
      |=> watchdog_tick_out)
    else $error("watchdog tick lost");

  cover property (cpu_int_req_out);
  cover property (irq_out);
  cover property (timer_increment_out && !opt_q[3]);
endmodule

bind coir_regs coir_regs_sva chk_u (
  .clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .instruction_cycle_clock_in,
  .watchdog_base_tick_in, .peripheral_int_pending_in,
  .timer_increment_out, .watchdog_tick_out,
  .port_b_pullup_disable_out, .cpu_int_req_out, .irq_out
);

`default_nettype wire

// *** verification/coir_regs_tb.sv ***
// Self-checking bench for coir_regs.
// Assumes the package, design and bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module coir_regs_tb;
  import coir_pkg::*;
  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  coir_byte_type reg_addr_in = 8'h00;
  coir_byte_type reg_wdata_in = 8'h00;
  coir_byte_type reg_rdata_out;
  logic          reg_wr_in = 1'b0;
  logic          reg_rd_in = 1'b0;
  logic          timer_ext_clock_pin_in = 1'b0;
  logic          ext_int_pin_in = 1'b0;
  logic [3:0]    port_b_a_upper_in = 4'h0;
  logic          instruction_cycle_clock_in = 1'b0;
  logic          port_b_read_in = 1'b0;
  logic          timer_overflow_in = 1'b0;
  logic          watchdog_base_tick_in = 1'b0;
  logic          peripheral_int_pending_in = 1'b0;
  logic          timer_increment_out;
  logic          watchdog_tick_out;
  logic          port_b_pullup_disable_out;
  logic          cpu_int_req_out;
  logic          irq_out;
  int            bad_count = 0;
  int            checks = 0;
  int            n_tinc = 0;
  int            n_wdo = 0;

  coir_regs dut_u (
    .clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .timer_ext_clock_pin_in,
    .ext_int_pin_in, .port_b_a_upper_in, .instruction_cycle_clock_in,
    .port_b_read_in, .timer_overflow_in, .watchdog_base_tick_in,
    .peripheral_int_pending_in, .timer_increment_out,
    .watchdog_tick_out, .port_b_pullup_disable_out, .cpu_int_req_out,
    .irq_out
  );

  initial forever #5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (timer_increment_out === 1'b1) n_tinc <= n_tinc + 1;
    if (watchdog_tick_out === 1'b1) n_wdo <= n_wdo + 1;
  end

  task automatic give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask
  task automatic cmp_cnt(input int g, e);
    cmp8(8'(g), 8'(e));
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 cmp8(reg_rdata_out, e);
  endtask

  task automatic t_reset;
    rd(8'h81, 8'hff);
    rd(8'h0b, 8'h00);
    cmp1(port_b_pullup_disable_out, 1'b1);
  endtask

  task automatic t_regs;
    wr(8'h81, 8'h5a);
    rd(8'h81, 8'h5a);
    cmp1(port_b_pullup_disable_out, 1'b0);
    wr(8'h81, 8'ha5);
    rd(8'h81, 8'ha5);
    wr(8'h0b, 8'hf8);
    rd(8'h0b, 8'hf8);
    wr(8'h0b, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    // Write and read back to back, no idle cycle between strobes
    @(posedge clk_in);
    reg_addr_in <= 8'h81;
    reg_wdata_in <= 8'h3c;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 cmp8(reg_rdata_out, 8'h3c);
    wr(8'h81, 8'hff);
  endtask

  task automatic t_flags;
    @(posedge clk_in);
    timer_overflow_in <= 1'b1;
    ext_int_pin_in <= 1'b1;
    port_b_a_upper_in <= 4'h8;
    @(posedge clk_in);
    timer_overflow_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rd(8'h0b, 8'h07);
    cmp1(cpu_int_req_out, 1'b0);
    rd(8'h90, 8'h07);
    wr(8'h91, 8'h02);
    #1 cmp1(irq_out, 1'b1);
    wr(8'h90, 8'h02);
    rd(8'h90, 8'h05);
    cmp1(irq_out, 1'b0);
    wr(8'h0b, 8'ha4);
    #1 cmp1(cpu_int_req_out, 1'b1);
    @(posedge clk_in);
    port_b_read_in <= 1'b1;
    @(posedge clk_in);
    port_b_read_in <= 1'b0;
    wr(8'h0b, 8'hc0);
    peripheral_int_pending_in <= 1'b1;
    #1 cmp1(cpu_int_req_out, 1'b1);
    wr(8'h0b, 8'h40);
    #1 cmp1(cpu_int_req_out, 1'b0);
    peripheral_int_pending_in <= 1'b0;
    rd(8'h0b, 8'h40);
  endtask

  // Source 0 instruction cycles, 1 timer pin rise, 2 watchdog base
  task automatic t_rate(input logic [7:0] opt, input int sel, n, e);
    int base;
    wr(8'h81, opt ^ 8'h08);
    wr(8'h81, opt);
    #1 base = (sel == 2) ? n_wdo : n_tinc;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      if (sel == 0) instruction_cycle_clock_in <= 1'b1;
      if (sel == 1) timer_ext_clock_pin_in <= 1'b1;
      if (sel == 2) watchdog_base_tick_in <= 1'b1;
      @(posedge clk_in);
      instruction_cycle_clock_in <= 1'b0;
      watchdog_base_tick_in <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    #1 cmp_cnt(((sel == 2) ? n_wdo : n_tinc) - base, e);
    @(posedge clk_in);
    timer_ext_clock_pin_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    if (sel == 1) begin
      cmp_cnt(n_tinc - base - e, int'(opt[4]));
    end
    if (sel == 2) begin
      rd(8'h90, 8'h0d);
      wr(8'h90, 8'h08);
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_flags;
    t_regs;
    t_rate(8'h08, 0, 6, 6);
    t_rate(8'h28, 1, 1, 1);
    t_rate(8'h38, 1, 1, 0);
    t_rate(8'h00, 0, 8, 4);
    t_rate(8'h02, 0, 16, 2);
    t_rate(8'h0a, 2, 16, 4);
    t_rate(8'h08, 2, 3, 3);
    t_rate(8'h02, 2, 5, 5);
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    give_verdict;
  end
endmodule

`default_nettype wire
